// *** src/p1g_pkg.sv ***
package p1g_pkg;
    // Port geometry
    localparam int PORT_WIDTH = 8;
    // Register byte addresses
    localparam logic [15:0] ADDR_OUTPUT_LATCH = 16'hFFD4;
    localparam logic [15:0] ADDR_DIRECTION = 16'hFFE4;
    localparam logic [15:0] ADDR_PULLUP = 16'hFFED;
    localparam logic [15:0] ADDR_FUNC_SELECT = 16'hFFFC;
    localparam logic [15:0] ADDR_ANALOG_PORT = 16'hFFDD;
    localparam logic [15:0] ADDR_ALT_STATUS = 16'hFFDE;
    // Reset values
    localparam logic [7:0] RST_OUTPUT_LATCH = 8'h00;
    localparam logic [7:0] RST_DIRECTION = 8'h00;
    localparam logic [7:0] RST_PULLUP = 8'h00;
    localparam logic [7:0] RST_FUNC_SELECT = 8'h04;
    // Fixed bits of the pin-function register
    localparam logic [7:0] FUNC_FIXED_MASK = 8'h0E;
    localparam logic [7:0] FUNC_FIXED_VALUE = 8'h04;
    // Pin-function bits that hand a pin to an alternate function
    localparam logic [7:0] FUNC_ALT_MASK = 8'hF1;
    // Alternate functions that drive the pin (bit 4 and bit 0)
    localparam logic [7:0] ALT_OUTPUT_MASK = 8'h11;
    localparam int FUNC_EXT_INTERRUPT_3_SELECT_BIT = 7;
    localparam int FUNC_EXT_INTERRUPT_1_SELECT_BIT = 5;
    localparam int FUNC_PWM_BIT = 4;
    localparam int FUNC_CLKOUT_BIT = 0;
    // Read answers
    localparam logic [7:0] DIRECTION_READ = 8'hFF;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam logic [7:0] IDLE_READ = 8'h00;
endpackage

// *** src/p1g_cfg_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface p1g_cfg_if;
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] pull;
    logic [7:0] funcSel;
    logic standby;
    logic pwmSrc;
    logic clkOutSrc;
    logic [7:0] altSel;
    logic [7:0] driveEn;
    logic [7:0] nextOut;
    logic [7:0] nextOe;
    logic [7:0] nextPull;
    modport regs (
        output latch, dir, pull, funcSel, standby, pwmSrc, clkOutSrc,
        input altSel, driveEn, nextOut, nextOe, nextPull
    );
    modport mux (
        input latch, dir, pull, funcSel, standby, pwmSrc, clkOutSrc,
        output altSel, driveEn, nextOut, nextOe, nextPull
    );
endinterface
`default_nettype wire

// *** src/p1g_pin_mux.sv ***
`timescale 1ns/1ps
`default_nettype none
module p1g_pin_mux (
    p1g_cfg_if.mux cfg // Configuration in, pin drive out
);
    // Alternate-output value for a pin
    function automatic logic [7:0] alt_value(input logic pwm, input logic clk);
        logic [7:0] v;
        v = 8'h00;
        v[p1g_pkg::FUNC_PWM_BIT] = pwm;
        v[p1g_pkg::FUNC_CLKOUT_BIT] = clk;
        return v;
    endfunction

    wire logic [7:0] gpioOe;
    wire logic [7:0] altOe;

    // General I/O only where the function register selects it
    assign cfg.altSel = cfg.funcSel & p1g_pkg::FUNC_ALT_MASK;
    assign gpioOe = cfg.dir & ~cfg.altSel;
    assign altOe = cfg.altSel & p1g_pkg::ALT_OUTPUT_MASK;
    assign cfg.driveEn = gpioOe | altOe;

    // Standby floats every pin; pull-ups stay as configured
    assign cfg.nextOe = cfg.standby ? 8'h00 : cfg.driveEn;
    assign cfg.nextOut = (cfg.latch & ~cfg.altSel)
        | (alt_value(cfg.pwmSrc, cfg.clkOutSrc) & altOe);
    // Pull-up only on a pin that is not driven
    assign cfg.nextPull = cfg.pull & ~cfg.driveEn;
endmodule
`default_nettype wire

// *** src/p1g_port.sv ***
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module p1g_port (
    input wire logic clk, // System clock, 40 MHz
    input wire logic rst_b, // Asynchronous reset, active low
    input wire logic [15:0] addr, // Register address
    input wire logic [7:0] wrData, // Write data
    input wire logic wrStrobe, // Write strobe
    input wire logic rdStrobe, // Read strobe
    output logic [7:0] rdData, // Read data, cycle after strobe
    input wire logic [7:0] pinIn, // Port pin levels
    output logic [7:0] pinOut, // Port pin output values
    output logic [7:0] pinOe, // Port pin output enables
    output logic [7:0] pinPullup, // Port pin pull-up enables
    input wire logic standby, // Standby mode request
    input wire logic pwmOut, // PWM source for pin 4
    input wire logic timerAClockOut, // Timer A clock for pin 0
    output logic [2:0] extIrqN, // Interrupt pins 3..1, active low
    input wire logic timerVSelect, // Timer V status selects match output
    input wire logic timerVMatchOut, // Timer V compare-match level
    output logic port7Bit6Out, // Port 7 bit 6 alternate value
    output logic port7Bit6AltSel, // Port 7 bit 6 under timer V
    input wire logic [1:0] timerXSelect, // Timer X output control, B and A
    input wire logic [1:0] timerXCompareOut, // Timer X compare B and A levels
    output logic [1:0] port8Out, // Port 8 bits 2 and 1 values
    output logic [1:0] port8AltSel, // Port 8 bits 2 and 1 under timer X
    input wire logic [7:0] analogPinIn, // Analog port pin levels
    output logic [7:0] analogToAdc // Analog inputs for the converter
);
    logic rstMeta;
    logic rstN;
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] pull;
    logic [7:0] funcSel;
    logic [7:0] pinSample;
    logic [7:0] analogSample;
    logic [7:0] next_rdData;

    p1g_cfg_if cfg ();

    // Reset release through two flip-flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN <= rstMeta;
        end
    end

    // Address decode
    wire logic hitLatch = (addr == p1g_pkg::ADDR_OUTPUT_LATCH);
    wire logic hitDir = (addr == p1g_pkg::ADDR_DIRECTION);
    wire logic hitPull = (addr == p1g_pkg::ADDR_PULLUP);
    wire logic hitFunc = (addr == p1g_pkg::ADDR_FUNC_SELECT);
    wire logic hitAnalog = (addr == p1g_pkg::ADDR_ANALOG_PORT);
    wire logic hitStatus = (addr == p1g_pkg::ADDR_ALT_STATUS);

    // Port read: latch for outputs, sampled pin for inputs
    wire logic [7:0] portRead = (latch & dir)
        | (pinSample & ~dir);
    wire logic [7:0] funcRead = (funcSel & ~p1g_pkg::FUNC_FIXED_MASK)
        | p1g_pkg::FUNC_FIXED_VALUE;
    wire logic [7:0] statusRead = {3'b000, port8AltSel, port7Bit6AltSel, 2'b00};

    // Read data selection
    always_comb begin
        next_rdData = p1g_pkg::IDLE_READ;
        if (rdStrobe) begin
            case (1'b1)
                hitLatch: next_rdData = portRead;
                hitDir: next_rdData = p1g_pkg::DIRECTION_READ;
                hitPull: next_rdData = pull;
                hitFunc: next_rdData = funcRead;
                hitAnalog: next_rdData = analogSample;
                hitStatus: next_rdData = statusRead;
                default: next_rdData = p1g_pkg::UNMAPPED_READ;
            endcase
        end
    end

    // Output latch
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            latch <= p1g_pkg::RST_OUTPUT_LATCH;
        end else if (wrStrobe && hitLatch) begin
            latch <= wrData;
        end
    end

    // Direction register
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            dir <= p1g_pkg::RST_DIRECTION;
        end else if (wrStrobe && hitDir) begin
            dir <= wrData;
        end
    end

    // Pull-up enables
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pull <= p1g_pkg::RST_PULLUP;
        end else if (wrStrobe && hitPull) begin
            pull <= wrData;
        end
    end

    // Pin-function register; fixed bits ignore writes
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            funcSel <= p1g_pkg::RST_FUNC_SELECT;
        end else if (wrStrobe && hitFunc) begin
            funcSel <= (wrData & ~p1g_pkg::FUNC_FIXED_MASK)
                | p1g_pkg::FUNC_FIXED_VALUE;
        end
    end

    // Pin and analog sampling, read data
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pinSample <= 8'h00;
            analogSample <= 8'h00;
            rdData <= p1g_pkg::IDLE_READ;
        end else begin
            pinSample <= pinIn;
            analogSample <= analogPinIn;
            rdData <= next_rdData;
        end
    end

    // Configuration to the pin multiplexer
    assign cfg.latch = latch;
    assign cfg.dir = dir;
    assign cfg.pull = pull;
    assign cfg.funcSel = funcSel;
    assign cfg.standby = standby;
    assign cfg.pwmSrc = pwmOut;
    assign cfg.clkOutSrc = timerAClockOut;

    p1g_pin_mux pinMux (
        .cfg(cfg.mux)
    );

    // Interrupt pins pass the pin level only when selected
    wire logic [2:0] next_extIrqN =
        pinSample[p1g_pkg::FUNC_EXT_INTERRUPT_3_SELECT_BIT:p1g_pkg::FUNC_EXT_INTERRUPT_1_SELECT_BIT]
        | ~funcSel[p1g_pkg::FUNC_EXT_INTERRUPT_3_SELECT_BIT:p1g_pkg::FUNC_EXT_INTERRUPT_1_SELECT_BIT];

    // Registered pin drive; reset floats all eight pins
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pinOut <= 8'h00;
            pinOe <= 8'h00;
            pinPullup <= 8'h00;
            extIrqN <= 3'b111;
        end else begin
            pinOut <= cfg.nextOut;
            pinOe <= cfg.nextOe;
            pinPullup <= cfg.nextPull;
            extIrqN <= next_extIrqN;
        end
    end

    // Port 7 and port 8 alternate outputs, analog inputs for the converter
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            port7Bit6Out <= 1'b0;
            port7Bit6AltSel <= 1'b0;
            port8Out <= 2'b00;
            port8AltSel <= 2'b00;
            analogToAdc <= 8'h00;
        end else begin
            port7Bit6Out <= timerVSelect & timerVMatchOut;
            port7Bit6AltSel <= timerVSelect;
            port8Out <= timerXSelect & timerXCompareOut;
            port8AltSel <= timerXSelect;
            analogToAdc <= analogSample;
        end
    end

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstN);

    a_read_output_bits: assert property (
        rdStrobe && hitLatch |=> ((rdData & $past(dir)) == ($past(latch) & $past(dir))))
        else $error("output-direction bit read did not return latch");

    a_read_input_bits: assert property (
        rdStrobe && hitLatch |=> ((rdData & ~$past(dir)) == ($past(pinIn, 2) & ~$past(dir))))
        else $error("input-direction bit read did not return pin level");

    a_oe_from_dir: assert property (
        !standby && funcSel == p1g_pkg::RST_FUNC_SELECT |=> pinOe == $past(dir))
        else $error("pin enable does not follow direction");

    a_alt_overrides_gpio: assert property (
        !standby && funcSel[p1g_pkg::FUNC_EXT_INTERRUPT_3_SELECT_BIT] |=> !pinOe[7])
        else $error("interrupt pin driven by general I/O");

    a_dir_reads_ones: assert property (
        rdStrobe && hitDir |=> rdData == 8'hFF)
        else $error("direction read not all ones");

    a_pullup_input_only: assert property (
        1'b1 |=> pinPullup == ($past(pull) & ~($past(dir) & ~$past(cfg.altSel))
            & ~$past(cfg.altSel & p1g_pkg::ALT_OUTPUT_MASK)))
        else $error("pull-up does not follow enable on input");

    a_reset_latch: assert property (
        $rose(rstN) |-> latch == 8'h00)
        else $error("latch not clear after reset");

    a_reset_dir: assert property (
        $rose(rstN) |-> dir == 8'h00 && pinOe == 8'h00)
        else $error("direction not clear after reset");

    a_reset_pull: assert property (
        $rose(rstN) |-> pull == 8'h00)
        else $error("pull-up not clear after reset");

    a_latch_write: assert property (
        wrStrobe && hitLatch |=> latch == $past(wrData))
        else $error("latch write lost");

    a_pull_write: assert property (
        wrStrobe && hitPull ##1 rdStrobe && hitPull |=> rdData == $past(wrData, 2))
        else $error("pull-up write not read back");

    a_func_reset: assert property (
        $rose(rstN) |-> funcSel == 8'h04)
        else $error("function register reset value wrong");

    a_timer_v_pin: assert property (
        1'b1 |=> port7Bit6Out == ($past(timerVSelect) & $past(timerVMatchOut)))
        else $error("port 7 bit 6 alternate value wrong");

    a_timer_x_pins: assert property (
        1'b1 |=> port8AltSel == $past(timerXSelect))
        else $error("port 8 alternate selection wrong");

    a_func_fixed_bits: assert property (
        rdStrobe && hitFunc |=> rdData[3:1] == 3'b010)
        else $error("function register fixed bits wrong");

    a_standby_float: assert property (
        standby |=> pinOe == 8'h00)
        else $error("pin driven in standby");

    a_output_no_pull: assert property (
        !standby && dir[3] |=> !pinPullup[3])
        else $error("pull-up on an output pin");

    c_mixed_read: cover property (rdStrobe && hitLatch && dir != 8'h00 && dir != 8'hFF);
    c_pwm_out: cover property (funcSel[p1g_pkg::FUNC_PWM_BIT] ##1 pinOe[4]);
    c_standby_pull: cover property (standby && pinPullup != 8'h00);
    c_func_write: cover property (wrStrobe && hitFunc ##1 rdStrobe && hitFunc);
endmodule
`default_nettype wire

// *** verification/p1g_pin_env.sv ***
`timescale 1ns/1ps
`default_nettype none
module p1g_pin_env (
    input wire logic clk, // Clock for the floating pattern
    input wire logic [7:0] pinOut, // Device drive value
    input wire logic [7:0] pinOe, // Device drive enable
    input wire logic [7:0] pinPullup, // Device pull-up enable
    input wire logic [7:0] extVal, // Outside circuit drive value
    input wire logic [7:0] extEn, // Outside circuit drive enable
    output logic [7:0] pinLevel // Resolved pin level
);
    logic [7:0] lastLevel = 8'h00;
    logic [7:0] resolved;
    // Device drive first, then outside drive, then pull-up, else a moving pattern
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pinOe[i]) resolved[i] = pinOut[i];
            else if (extEn[i]) resolved[i] = extVal[i];
            else if (pinPullup[i]) resolved[i] = 1'b1;
            else resolved[i] = ~lastLevel[i];
        end
    end
    // A released line toggles so stale values never pass for a match
    always_ff @(posedge clk) lastLevel <= resolved;
    assign pinLevel = resolved;
endmodule
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wrData = 8'h00;
    logic wrStrobe = 1'b0;
    logic rdStrobe = 1'b0;
    logic standby = 1'b0;
    logic pwmOut = 1'b0;
    logic timerAClockOut = 1'b0;
    logic timerVSelect = 1'b0;
    logic timerVMatchOut = 1'b0;
    logic [1:0] timerXSelect = 2'h0;
    logic [1:0] timerXCompareOut = 2'h0;
    logic [7:0] analogPinIn = 8'h00;
    logic [7:0] extVal = 8'h00;
    logic [7:0] extEn = 8'hFF;
    logic [7:0] rdData, pinOut, pinOe, pinPullup, pinLevel, analogToAdc;
    logic [2:0] extIrqN;
    logic port7Bit6Out, port7Bit6AltSel;
    logic [1:0] port8Out, port8AltSel;
    int err_total = 0;
    int cmp_count = 0;
    int cycles = 0;
    int mLat, mDir, mPull, mFunc;

    p1g_port i_p1g_port (.clk(clk), .rst_b(rst_b), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .pinIn(pinLevel),
        .pinOut(pinOut), .pinOe(pinOe), .pinPullup(pinPullup), .standby(standby),
        .pwmOut(pwmOut), .timerAClockOut(timerAClockOut), .extIrqN(extIrqN),
        .timerVSelect(timerVSelect), .timerVMatchOut(timerVMatchOut),
        .port7Bit6Out(port7Bit6Out), .port7Bit6AltSel(port7Bit6AltSel),
        .timerXSelect(timerXSelect), .timerXCompareOut(timerXCompareOut),
        .port8Out(port8Out), .port8AltSel(port8AltSel), .analogPinIn(analogPinIn),
        .analogToAdc(analogToAdc));
    p1g_pin_env i_p1g_pin_env (.clk(clk), .pinOut(pinOut), .pinOe(pinOe),
        .pinPullup(pinPullup), .extVal(extVal), .extEn(extEn), .pinLevel(pinLevel));

    // Clock at 40 MHz
    initial begin
        forever #12.5 clk = ~clk;
    end

    // Cuts a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Bus write, mirrored into the model
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
        if (a == 16'hFFD4) mLat = d;
        if (a == 16'hFFE4) mDir = d;
        if (a == 16'hFFED) mPull = d;
        if (a == 16'hFFFC) mFunc = (d & 8'hF1) | 8'h04;
    endtask

    // Bus read, data checked in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        #1;
        chk(rdData, e);
    endtask

    // Write, then read the same address on the very next cycle
    task automatic wr_rd(input logic [15:0] a, input logic [7:0] d, input logic [7:0] e);
        wr(a, d);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        #1;
        chk(rdData, e);
    endtask

    // Reset through the synchroniser and check the values it leaves
    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(pinOe, 8'h00);
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        mLat = 0;
        mDir = 0;
        mPull = 0;
        mFunc = 4;
        rd(16'hFFE4, 8'hFF);
        rd(16'hFFED, 8'h00);
        rd(16'hFFFC, 8'h04);
        wr(16'hFFE4, 8'hFF);
        rd(16'hFFD4, 8'h00);
        wr(16'hFFE4, 8'h00);
    endtask

    // Compare every output and the readable registers with the model
    task automatic check_all();
        logic [7:0] drv, outv, lvl, irq;
        drv = 8'((mDir & ~(mFunc & 8'hF1)) | (mFunc & 8'h11));
        outv = 8'(mLat);
        outv[4] = mFunc[4] ? pwmOut : outv[4];
        outv[0] = mFunc[0] ? timerAClockOut : outv[0];
        lvl = (drv & outv) | (~drv & ((extEn & extVal) | (~extEn & 8'(mPull))));
        irq = {5'h00, mFunc[7] ? lvl[7] : 1'b1, mFunc[6] ? lvl[6] : 1'b1, mFunc[5] ? lvl[5] : 1'b1};
        repeat (3) @(posedge clk);
        #1;
        chk(pinOe, drv);
        chk(pinOut & drv, outv & drv);
        chk(pinPullup, 8'(mPull) & ~drv);
        chk({5'h00, extIrqN}, irq);
        chk({2'h0, port7Bit6AltSel, port7Bit6Out, port8AltSel, port8Out},
            {2'h0, timerVSelect, timerVSelect & timerVMatchOut, timerXSelect,
            timerXSelect & timerXCompareOut});
        chk(analogToAdc, analogPinIn);
        rd(16'hFFD4, 8'((mLat & mDir) | (lvl & ~mDir)));
        rd(16'hFFED, 8'(mPull));
        rd(16'hFFFC, 8'(mFunc));
        rd(16'hFFE4, 8'hFF);
        rd(16'hFFDD, analogPinIn);
        rd(16'hFFDE, {3'h0, timerXSelect, timerVSelect, 2'h0});
    endtask

    // Main sequence
    initial begin
        void'($urandom(6493));
        do_reset();
        wr_rd(16'hFFED, 8'h5A, 8'h5A);
        wr_rd(16'hFFFC, 8'h31, 8'h35);
        wr(16'hFFFC, 8'hFF);
        rd(16'hFFFC, 8'hF5);
        wr(16'hFFFC, 8'h00);
        rd(16'hFFFC, 8'h04);
        wr(16'hFF00, 8'hAA);
        rd(16'hFF00, 8'h00);
        // Released pins with pull-ups read high, driven pins keep them off
        @(posedge clk);
        extEn <= 8'h00;
        wr(16'hFFED, 8'hFF);
        wr(16'hFFD4, 8'h05);
        wr(16'hFFE4, 8'h0F);
        check_all();
        @(posedge clk);
        standby <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk(pinOe, 8'h00);
        chk(pinPullup, 8'hF0);
        standby <= 1'b0;
        extEn <= 8'hFF;
        // Random configurations and pin traffic
        for (int n = 0; n < 40; n++) begin
            @(posedge clk);
            extVal <= 8'($urandom);
            {pwmOut, timerAClockOut, timerVSelect, timerVMatchOut} <= 4'($urandom);
            {timerXSelect, timerXCompareOut} <= 4'($urandom);
            analogPinIn <= 8'($urandom);
            wr(16'hFFFC, 8'($urandom));
            wr(16'hFFE4, 8'($urandom));
            wr(16'hFFD4, 8'($urandom));
            wr(16'hFFED, 8'($urandom));
            check_all();
        end
        do_reset();
        check_all();
        end_of_test();
    end
endmodule
`default_nettype wire
